/* dva_pkg.sv */
// What this block does
// - Left zero samples are counted in a row and left auto-mute is permitted once the 3-bit left threshold is met.
// - Right zero samples are counted on their own against a separate 3-bit threshold with the same eight codes.
// - Thresholds are sample counts, exact at 96 kHz, so the real time scales with the sample rate.
// - Link mode 00 keeps both volumes independent and 01 makes the right channel use the left volume code.
// - Gain code 0x00 is +24 dB, each step is 0.5 dB lower, 0x30 is 0 dB, 0xfe is -103 dB and 0xff mutes.
// - The left volume code sets the left channel gain.
// - The right volume code sets the right channel gain unless the link mode makes it follow the left code.
// - Ramping down updates every 1, 2 or 4 sample periods, or jumps straight to the target code for rate code 11.
// - Each ramp-down update lowers the gain by 4, 2, 1 or 0.5 dB for step codes 00 to 11.
// - Ramping up updates every 1, 2 or 4 sample periods or restores at once, raising gain by 4, 2, 1 or 0.5 dB.
package dva_pkg;

    localparam logic [7:0] DVA_ADDR_MUTE_TIME = 8'h3b;
    localparam logic [7:0] DVA_ADDR_LINK      = 8'h3c;
    localparam logic [7:0] DVA_ADDR_LEFT_VOL  = 8'h3d;
    localparam logic [7:0] DVA_ADDR_RIGHT_VOL = 8'h3e;
    localparam logic [7:0] DVA_ADDR_RAMP      = 8'h3f;

    localparam logic [7:0] DVA_RST_MUTE_TIME = 8'h00;
    localparam logic [7:0] DVA_RST_LINK      = 8'h00;
    localparam logic [7:0] DVA_RST_LEFT_VOL  = 8'h10;
    localparam logic [7:0] DVA_RST_RIGHT_VOL = 8'h30;
    localparam logic [7:0] DVA_RST_RAMP      = 8'h11;

    localparam int DVA_LEFT_TIME_LSB  = 4;
    localparam int DVA_RIGHT_TIME_LSB = 0;
    localparam int DVA_RDN_RATE_LSB   = 6;
    localparam int DVA_RDN_STEP_LSB   = 4;
    localparam int DVA_RUP_RATE_LSB   = 2;
    localparam int DVA_RUP_STEP_LSB   = 0;

    localparam logic [7:0] DVA_MUTE_TIME_MASK = 8'h77;
    localparam logic [7:0] DVA_LINK_MASK      = 8'h03;
    localparam logic [1:0] DVA_LINK_FOLLOW    = 2'h1;
    localparam logic [7:0] DVA_MUTE_CODE      = 8'hff;
    localparam logic [1:0] DVA_RATE_INSTANT   = 2'h3;

    localparam int DVA_SMP_W   = 24;
    localparam int DVA_CNT_W   = 19;
    localparam int DVA_MANT_W  = 16;
    localparam int DVA_FRAC_SH = 11;
    localparam int DVA_STEPS_PER_6DB = 12;

    // Zero-run lengths in microseconds at the reference rate; counts are samples.
    localparam longint DVA_REF_RATE_HZ = 96000;
    localparam longint DVA_US_PER_S    = 1000000;
    localparam longint DVA_TIME_US [8] = '{11500, 53000, 106500, 266500, 535000, 1065000, 2665000, 5330000};

    typedef enum logic [1:0] {DVA_HOLD, DVA_DOWN, DVA_UP} dva_dir_type;

    function automatic logic [DVA_CNT_W-1:0] dva_zero_limit(input logic [2:0] sel);
        dva_zero_limit = DVA_CNT_W'((DVA_TIME_US[sel] * DVA_REF_RATE_HZ) / DVA_US_PER_S);
    endfunction : dva_zero_limit

    function automatic logic [7:0] dva_step_codes(input logic [1:0] step);
        dva_step_codes = 8'h08 >> step;
    endfunction : dva_step_codes

    function automatic logic [DVA_MANT_W-1:0] dva_mantissa(input logic [3:0] r);
        unique case (r)
            4'h0:    dva_mantissa = 16'h8000;
            4'h1:    dva_mantissa = 16'h78d7;
            4'h2:    dva_mantissa = 16'h7215;
            4'h3:    dva_mantissa = 16'h6bb3;
            4'h4:    dva_mantissa = 16'h65ad;
            4'h5:    dva_mantissa = 16'h5ffd;
            4'h6:    dva_mantissa = 16'h5a9e;
            4'h7:    dva_mantissa = 16'h558c;
            4'h8:    dva_mantissa = 16'h50c3;
            4'h9:    dva_mantissa = 16'h4c3f;
            4'ha:    dva_mantissa = 16'h47fb;
            4'hb:    dva_mantissa = 16'h43f4;
            default: dva_mantissa = 16'h0000;
        endcase
    endfunction : dva_mantissa

endpackage : dva_pkg

/* dva_zero_run.sv */
`timescale 1ns/1ns
module dva_zero_run
    import dva_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       sample_valid,
    input  wire logic       sample_is_zero,
    input  wire logic [2:0] limit_sel,
    output logic            mute_ok
);
    logic [DVA_CNT_W-1:0] run_ff;
    logic [DVA_CNT_W-1:0] nxt_run;
    logic                 ok_ff;
    logic                 nxt_ok;
    wire  logic           at_top = &run_ff;

    // The run saturates so a long silence never wraps back into sound.
    assign nxt_run = !sample_valid ? run_ff : (!sample_is_zero ? '0 : (at_top ? run_ff : run_ff + 1'b1));
    assign nxt_ok  = nxt_run >= dva_zero_limit(limit_sel);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            run_ff <= '0;
            ok_ff  <= 1'b0;
        end
        else
        begin
            run_ff <= nxt_run;
            ok_ff  <= nxt_ok;
        end
    end

    assign mute_ok = ok_ff;

endmodule : dva_zero_run

/* dva_volume.sv */
`timescale 1ns/1ns
module dva_volume
    import dva_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_we,
    output logic      [7:0]           reg_rdata,
    input  wire logic                 sample_valid,
    input  wire logic [DVA_SMP_W-1:0] left_in,
    input  wire logic [DVA_SMP_W-1:0] right_in,
    input  wire logic                 soft_mute_req,
    output logic                      out_valid,
    output logic      [DVA_SMP_W-1:0] left_out,
    output logic      [DVA_SMP_W-1:0] right_out,
    output logic                      left_mute_ok,
    output logic                      right_mute_ok
);
    logic [7:0] mute_time_ff;
    logic [7:0] link_ff;
    logic [7:0] left_vol_ff;
    logic [7:0] right_vol_ff;
    logic [7:0] ramp_ff;
    logic [7:0] rdata_ff;
    logic       valid_ff;

    wire logic we_mute_time = reg_we && (reg_addr == DVA_ADDR_MUTE_TIME);
    wire logic we_link      = reg_we && (reg_addr == DVA_ADDR_LINK);
    wire logic we_left      = reg_we && (reg_addr == DVA_ADDR_LEFT_VOL);
    wire logic we_right     = reg_we && (reg_addr == DVA_ADDR_RIGHT_VOL);
    wire logic we_ramp      = reg_we && (reg_addr == DVA_ADDR_RAMP);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mute_time_ff <= DVA_RST_MUTE_TIME;
            link_ff      <= DVA_RST_LINK;
            left_vol_ff  <= DVA_RST_LEFT_VOL;
            right_vol_ff <= DVA_RST_RIGHT_VOL;
            ramp_ff      <= DVA_RST_RAMP;
        end
        else
        begin
            if (we_mute_time)
            begin
                mute_time_ff <= reg_wdata & DVA_MUTE_TIME_MASK;
            end
            if (we_link)
            begin
                link_ff <= reg_wdata & DVA_LINK_MASK;
            end
            if (we_left)
            begin
                left_vol_ff <= reg_wdata;
            end
            if (we_right)
            begin
                right_vol_ff <= reg_wdata;
            end
            if (we_ramp)
            begin
                ramp_ff <= reg_wdata;
            end
        end
    end

    // Reserved bits read as zero; unmapped addresses read as zero.
    wire logic [7:0] rd_mux = (reg_addr == DVA_ADDR_MUTE_TIME) ? mute_time_ff :
                              (reg_addr == DVA_ADDR_LINK)      ? link_ff      :
                              (reg_addr == DVA_ADDR_LEFT_VOL)  ? left_vol_ff  :
                              (reg_addr == DVA_ADDR_RIGHT_VOL) ? right_vol_ff :
                              (reg_addr == DVA_ADDR_RAMP)      ? ramp_ff      : 8'h00;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_ff <= 8'h00;
            valid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= rd_mux;
            valid_ff <= sample_valid;
        end
    end

    wire logic [2:0] left_zero_mute_time  = mute_time_ff[DVA_LEFT_TIME_LSB +: 3];
    wire logic [2:0] right_zero_mute_time = mute_time_ff[DVA_RIGHT_TIME_LSB +: 3];
    wire logic [1:0] volume_link_mode     = link_ff[1:0];
    wire logic [1:0] ramp_down_rate       = ramp_ff[DVA_RDN_RATE_LSB +: 2];
    wire logic [1:0] ramp_down_step       = ramp_ff[DVA_RDN_STEP_LSB +: 2];
    wire logic [1:0] ramp_up_rate         = ramp_ff[DVA_RUP_RATE_LSB +: 2];
    wire logic [1:0] ramp_up_step         = ramp_ff[DVA_RUP_STEP_LSB +: 2];

    wire logic [7:0] left_gain_code  = left_vol_ff;
    // Modes 10 and 11 have no defined meaning and behave as independent.
    wire logic [7:0] right_gain_code = (volume_link_mode == DVA_LINK_FOLLOW) ? left_vol_ff : right_vol_ff;

    logic [DVA_SMP_W-1:0] smp_in  [2];
    logic [DVA_SMP_W-1:0] smp_out [2];
    logic [7:0]           prog    [2];
    logic [2:0]           lim_sel [2];
    logic                 zero_ok [2];

    assign smp_in[0]  = left_in;
    assign smp_in[1]  = right_in;
    assign prog[0]    = left_gain_code;
    assign prog[1]    = right_gain_code;
    assign lim_sel[0] = left_zero_mute_time;
    assign lim_sel[1] = right_zero_mute_time;

    localparam logic signed [DVA_SMP_W:0] SAT_HI = (DVA_SMP_W+1)'((1 << (DVA_SMP_W-1)) - 1);
    localparam logic signed [DVA_SMP_W:0] SAT_LO = -(DVA_SMP_W+1)'(1 << (DVA_SMP_W-1));

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_ch
            logic [7:0]           cur_ff;
            logic [1:0]           div_ff;
            logic [DVA_SMP_W-1:0] out_ff;
            logic [7:0]           nxt_cur;
            logic [1:0]           nxt_div;
            logic [DVA_SMP_W-1:0] nxt_out;
            dva_dir_type          dir;

            // A soft mute ramps toward the mute code, otherwise toward the programmed code.
            wire logic [7:0] target   = soft_mute_req ? DVA_MUTE_CODE : prog[ch];
            assign dir = (target > cur_ff) ? DVA_DOWN : ((target < cur_ff) ? DVA_UP : DVA_HOLD);
            wire logic [1:0] rate     = (dir == DVA_DOWN) ? ramp_down_rate : ramp_up_rate;
            wire logic [7:0] step     = dva_step_codes((dir == DVA_DOWN) ? ramp_down_step : ramp_up_step);
            wire logic [1:0] last_div = 2'((3'h1 << rate) - 3'h1);
            wire logic       tick     = (div_ff >= last_div);
            wire logic [7:0] gap      = (dir == DVA_DOWN) ? (target - cur_ff) : (cur_ff - target);
            wire logic [7:0] moved    = (gap <= step) ? target :
                                        ((dir == DVA_DOWN) ? (cur_ff + step) : (cur_ff - step));

            always_comb
            begin
                nxt_cur = cur_ff;
                nxt_div = div_ff;
                if (sample_valid)
                begin
                    if (dir == DVA_HOLD)
                    begin
                        nxt_div = 2'h0;
                    end
                    else if (rate == DVA_RATE_INSTANT)
                    begin
                        nxt_cur = target;
                        nxt_div = 2'h0;
                    end
                    else if (tick)
                    begin
                        nxt_cur = moved;
                        nxt_div = 2'h0;
                    end
                    else
                    begin
                        nxt_div = div_ff + 2'h1;
                    end
                end
            end

            // Gain split into whole 6 dB octaves (shift) and twelfths (mantissa table).
            wire logic [4:0]                   octave  = 5'(cur_ff / DVA_STEPS_PER_6DB);
            wire logic [3:0]                   twelfth = 4'(cur_ff % DVA_STEPS_PER_6DB);
            wire logic [5:0]                   shamt   = 6'(DVA_FRAC_SH) + {1'b0, octave};
            wire logic signed [DVA_MANT_W:0]   mant    = $signed({1'b0, dva_mantissa(twelfth)});
            wire logic signed [DVA_SMP_W+DVA_MANT_W:0] prod = $signed(smp_in[ch]) * mant;
            wire logic signed [DVA_SMP_W+DVA_MANT_W:0] scaled = prod >>> shamt;
            // Up to +24 dB of boost can overflow the word, so the result clips rather than wraps.
            wire logic [DVA_SMP_W-1:0] clipped = (scaled > SAT_HI) ? SAT_HI[DVA_SMP_W-1:0] :
                                                 (scaled < SAT_LO) ? SAT_LO[DVA_SMP_W-1:0] :
                                                 scaled[DVA_SMP_W-1:0];
            assign nxt_out = (cur_ff == DVA_MUTE_CODE) ? '0 : clipped;

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    cur_ff <= DVA_MUTE_CODE;
                    div_ff <= 2'h0;
                    out_ff <= '0;
                end
                else
                begin
                    cur_ff <= nxt_cur;
                    div_ff <= nxt_div;
                    if (sample_valid)
                    begin
                        out_ff <= nxt_out;
                    end
                end
            end

            assign smp_out[ch] = out_ff;

            dva_zero_run u_zero_run (
                .clk            (clk),
                .rst            (rst),
                .sample_valid   (sample_valid),
                .sample_is_zero (smp_in[ch] == '0),
                .limit_sel      (lim_sel[ch]),
                .mute_ok        (zero_ok[ch])
            );
        end
    endgenerate

    assign reg_rdata     = rdata_ff;
    assign out_valid     = valid_ff;
    assign left_out      = smp_out[0];
    assign right_out     = smp_out[1];
    assign left_mute_ok  = zero_ok[0];
    assign right_mute_ok = zero_ok[1];

endmodule : dva_volume

/* dva_volume_assertions.sv */
`timescale 1ns/1ns
module dva_volume_chk
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_we,
    input wire logic [7:0]  reg_rdata,
    input wire logic        sample_valid,
    input wire logic [23:0] left_in,
    input wire logic [23:0] right_in,
    input wire logic        soft_mute_req,
    input wire logic        out_valid,
    input wire logic [23:0] left_out,
    input wire logic [23:0] right_out,
    input wire logic        left_mute_ok,
    input wire logic        right_mute_ok
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence left_write;
        reg_we && reg_addr == 8'h3d;
    endsequence
    sequence left_held;
        !reg_we && reg_addr == 8'h3d;
    endsequence
    valid_follow_a: assert property (out_valid == $past(sample_valid))
        else $error("out_valid not one cycle after a sample");
    out_steady_a: assert property (($changed(left_out) || $changed(right_out)) |-> $past(sample_valid))
        else $error("output moved without a sample");
    left_silent_a: assert property (sample_valid && left_in == 24'h0 |=> left_out == 24'h0)
        else $error("zero left sample gave nonzero output");
    right_silent_a: assert property (sample_valid && right_in == 24'h0 |=> right_out == 24'h0)
        else $error("zero right sample gave nonzero output");
    left_readback_a: assert property (left_write ##1 left_held |=> reg_rdata == $past(reg_wdata, 2))
        else $error("left volume readback wrong");
    link_reserved_a: assert property (reg_addr == 8'h3c |=> reg_rdata[7:2] == 6'h0)
        else $error("link register reserved bits set");
    time_reserved_a: assert property (reg_addr == 8'h3b |=> !reg_rdata[7] && !reg_rdata[3])
        else $error("mute time reserved bits set");
    left_run_clear_a: assert property (sample_valid && left_in != 24'h0 |=> !left_mute_ok)
        else $error("left mute permit kept after nonzero sample");
    right_run_clear_a: assert property (sample_valid && right_in != 24'h0 |=> !right_mute_ok)
        else $error("right mute permit kept after nonzero sample");
endmodule : dva_volume_chk

bind dva_volume dva_volume_chk u_chk
(
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid), .left_in(left_in), .right_in(right_in),
    .soft_mute_req(soft_mute_req), .out_valid(out_valid), .left_out(left_out),
    .right_out(right_out), .left_mute_ok(left_mute_ok), .right_mute_ok(right_mute_ok)
);

/* dva_sample_src.sv */
`timescale 1ns/1ns
module dva_sample_src
(
    input  wire logic        clk,
    output logic             sample_valid,
    output logic [23:0]      left_in,
    output logic [23:0]      right_in
);
    initial
    begin
        sample_valid = 1'b0;
        left_in      = 24'h0;
        right_in     = 24'h0;
    end
    // Data is inverted outside the strobe so a stale sample can never pass for a fresh one.
    task automatic send(input int n, input int gap, input logic [23:0] l, input logic [23:0] r);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            sample_valid = 1'b1;
            left_in      = l;
            right_in     = r;
            @(posedge clk);
            #1;
            sample_valid = 1'b0;
            left_in      = ~l;
            right_in     = ~r;
            repeat (gap) @(posedge clk);
        end
    endtask : send
endmodule : dva_sample_src

/* dva_volume_tb.sv */
`timescale 1ns/1ns
module dva_volume_tb;
    logic        clk;
    logic        rst;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_we;
    logic        soft_mute_req;
    logic [7:0]  reg_rdata;
    logic        sample_valid;
    logic        out_valid;
    logic [23:0] left_in;
    logic [23:0] right_in;
    logic [23:0] left_out;
    logic [23:0] right_out;
    logic        left_mute_ok;
    logic        right_mute_ok;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cyc = 0;

    dva_volume DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_rdata(reg_rdata), .sample_valid(sample_valid), .left_in(left_in), .right_in(right_in),
        .soft_mute_req(soft_mute_req), .out_valid(out_valid), .left_out(left_out), .right_out(right_out),
        .left_mute_ok(left_mute_ok), .right_mute_ok(right_mute_ok));
    dva_sample_src src (.clk(clk), .sample_valid(sample_valid), .left_in(left_in), .right_in(right_in));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // The longest test is the auto-mute run of about ten thousand cycles.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_we    = 1'b1;
        @(posedge clk);
        #1;
        reg_we    = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1;
        reg_addr = a;
        repeat (2) @(posedge clk);
        #1;
        chk({16'h0, reg_rdata}, {16'h0, e});
    endtask : rd

    initial
    begin
        rst           = 1'b1;
        reg_addr      = 8'h0;
        reg_wdata     = 8'h0;
        reg_we        = 1'b0;
        soft_mute_req = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        rd(8'h3b, 8'h00);
        rd(8'h3c, 8'h00);
        rd(8'h3d, 8'h10);
        rd(8'h3e, 8'h30);
        rd(8'h3f, 8'h11);
        rd(8'h40, 8'h00);
        wr(8'h3b, 8'hff);
        rd(8'h3b, 8'h77);
        wr(8'h3c, 8'hff);
        rd(8'h3c, 8'h03);
        $display("test registers done");
        wr(8'h3c, 8'h00);
        wr(8'h3b, 8'h00);
        wr(8'h3f, 8'hff);
        wr(8'h3d, 8'h00);
        wr(8'h3e, 8'h3c);
        src.send(2, 0, 24'h400, 24'h400);
        chk(left_out, 24'h4000);
        chk(right_out, 24'h200);
        wr(8'h3d, 8'hff);
        src.send(2, 0, 24'h400, 24'h400);
        chk(left_out, 24'h0);
        wr(8'h3c, 8'h01);
        src.send(2, 1, 24'h400, 24'h400);
        chk(right_out, 24'h0);
        wr(8'h3c, 8'h00);
        wr(8'h3d, 8'h30);
        src.send(2, 0, 24'h400, 24'h400);
        chk(right_out, 24'h200);
        chk(left_out, 24'h400);
        $display("test gain done");
        soft_mute_req = 1'b1;
        src.send(2, 0, 24'h400, 24'h400);
        chk(left_out | right_out, 24'h0);
        soft_mute_req = 1'b0;
        src.send(2, 0, 24'h400, 24'h400);
        chk(left_out, 24'h400);
        // Step code 00 moves eight codes per sample, so 0x48 is reached only after three updates.
        wr(8'h3f, 8'h0f);
        wr(8'h3d, 8'h48);
        src.send(2, 0, 24'h400, 24'h400);
        chk(24'(left_out == 24'h100), 24'h0);
        src.send(2, 0, 24'h400, 24'h400);
        chk(left_out, 24'h100);
        wr(8'h3f, 8'h08);
        wr(8'h3d, 8'h30);
        src.send(8, 0, 24'h400, 24'h400);
        chk(24'(left_out == 24'h400), 24'h0);
        src.send(6, 2, 24'h400, 24'h400);
        chk(left_out, 24'h400);
        // Rate code 01 updates on every second sample, so twelve codes at four a step take six samples.
        wr(8'h3f, 8'h56);
        wr(8'h3d, 8'h3c);
        src.send(5, 0, 24'h400, 24'h400);
        chk(24'(left_out == 24'h200), 24'h0);
        src.send(2, 0, 24'h400, 24'h400);
        chk(left_out, 24'h200);
        // Coming back at two codes a step on every second sample takes twelve samples.
        wr(8'h3d, 8'h30);
        src.send(12, 0, 24'h400, 24'h400);
        chk(24'(left_out == 24'h400), 24'h0);
        src.send(1, 0, 24'h400, 24'h400);
        chk(left_out, 24'h400);
        $display("test ramp done");
        wr(8'h3b, 8'h10);
        src.send(1103, 0, 24'h0, 24'h0);
        chk(24'(right_mute_ok), 24'h0);
        src.send(1, 0, 24'h0, 24'h0);
        chk(24'(right_mute_ok), 24'h1);
        chk(24'(left_mute_ok), 24'h0);
        src.send(3983, 0, 24'h0, 24'h0);
        chk(24'(left_mute_ok), 24'h0);
        src.send(1, 0, 24'h0, 24'h0);
        chk(24'(left_mute_ok), 24'h1);
        src.send(1, 0, 24'h1, 24'h0);
        chk(24'(left_mute_ok), 24'h0);
        chk(24'(right_mute_ok), 24'h1);
        $display("test auto mute done");
        print_verdict();
    end
endmodule : dva_volume_tb
